// ===== logic/ppgm_cfg.svh
/*
  Constants for the parallel programming port controller: register offsets,
  command codes, action codes, field positions and timing counts.
  Assumes a 50 MHz core clock and inclusion by bare name.
*/
`ifndef PPGM_CFG_SVH
`define PPGM_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses on APB).
`define PPGM_OFS_CTRL       12'h000
`define PPGM_OFS_ADDR       12'h004
`define PPGM_OFS_WDATA      12'h008
`define PPGM_OFS_STATUS     12'h00c
`define PPGM_OFS_RDATA      12'h010

// ==========================================================================
// Control register fields.
`define PPGM_CTRL_OP_LSB    0
`define PPGM_CTRL_START_BIT 4
`define PPGM_CTRL_HALF_BIT  5
`define PPGM_CTRL_CMDLD_BIT 6
`define PPGM_CTRL_ADRHI_BIT 7

// ==========================================================================
// Device command bytes.
`define PPGM_CMD_CHIP_ERASE 8'h80
`define PPGM_CMD_WR_FUSE    8'h40
`define PPGM_CMD_WR_LOCK    8'h20
`define PPGM_CMD_WR_EEPROM  8'h11
`define PPGM_CMD_RD_SIG     8'h08
`define PPGM_CMD_RD_FUSELK  8'h04
`define PPGM_CMD_RD_FLASH   8'h02
`define PPGM_CMD_RD_EEPROM  8'h03

// Action codes presented on the action code pins.
`define PPGM_ACT_ADDR       2'h0
`define PPGM_ACT_DATA       2'h1
`define PPGM_ACT_CMD        2'h2
`define PPGM_ACT_IDLE       2'h3

// Fuse and lock masks: reserved bits are forced to one.
`define PPGM_FUSE_KEEP_MASK 8'h2b
`define PPGM_LOCK_KEEP_MASK 8'h06
`define PPGM_EE_ADRHI_MAX   8'h0f
`define PPGM_BLANK_BYTE     8'hff

// ==========================================================================
// Timing.
`define PPGM_CLK_HZ         50000000
`define PPGM_STEP_NS        100
// Worked in MHz so that the product stays inside 32-bit arithmetic.
`define PPGM_STEP_CYC       ((`PPGM_STEP_NS * (`PPGM_CLK_HZ / 1000000) + 999) / 1000)
`define PPGM_FUSE_PULSE_US  1400
`define PPGM_FUSE_PULSE_CYC ((`PPGM_FUSE_PULSE_US * (`PPGM_CLK_HZ / 1000000)))
`define PPGM_ERASE_PULSE_US 15000
`define PPGM_ERASE_PULSE_CYC ((`PPGM_ERASE_PULSE_US * (`PPGM_CLK_HZ / 1000000)))

`endif

// ===== logic/ppgm_pkg.sv
/*
  Types for the parallel programming port controller.
  Assumes ppgm_cfg.svh supplies every numeric constant.
*/
`default_nettype none
package ppgm_pkg;
  // ========================================================================
  // Operations software can start.
  typedef enum logic [3:0] {
    PPGM_OP_WR_EEPROM,
    PPGM_OP_RD_EEPROM,
    PPGM_OP_RD_FLASH,
    PPGM_OP_WR_FUSE,
    PPGM_OP_WR_LOCK,
    PPGM_OP_RD_FUSELK,
    PPGM_OP_RD_SIG,
    PPGM_OP_CHIP_ERASE
  } ppgm_op_e;

  // Pin outputs toward the device, kept together.
  typedef struct packed {
    logic [1:0] action_code;
    logic       byte_half_select;
    logic       load_strobe;
    logic       write_pulse_n;
    logic       output_enable_n;
    logic [7:0] data_out;
    logic       data_oe_n;
  } ppgm_pins_s;
endpackage
`default_nettype wire

// ===== logic/ppgm_host.sv
/*
  Parallel programming host: an APB slave register file that sequences
  command, address and data loads and write or read strobes on the device.
  Assumes the device is already in programming mode and its pins are wired
  to this module; the data bus is resolved outside from the enable.
*/
`include "ppgm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ppgm_host
(
  input  wire logic        CORE_CLK,          // Core clock, 50 MHz.
  input  wire logic        SYS_RST,           // Asynchronous reset, high.
  input  wire logic        PSEL,              // APB select.
  input  wire logic        PENABLE,           // APB access phase.
  input  wire logic        PWRITE,            // APB direction.
  input  wire logic [11:0] PADDR,             // APB byte address.
  input  wire logic [31:0] PWDATA,            // APB write data.
  output logic      [31:0] PRDATA,            // APB read data.
  output logic             PREADY,            // APB ready.
  output logic             PSLVERR,           // APB error, unmapped address.
  output logic      [1:0]  ACTION_CODE,       // Action code hi and lo.
  output logic             BYTE_HALF_SELECT,  // Byte half select.
  output logic             LOAD_STROBE,       // Load strobe, positive pulse.
  output logic             WRITE_PULSE_N,     // Program pulse, active low.
  output logic             OUTPUT_ENABLE_N,   // Device output enable, low.
  output logic      [7:0]  DATA_OUT,          // Data bus drive value.
  output logic             DATA_OE_N,         // Data bus drive enable, low.
  input  wire logic [7:0]  DATA_IN,           // Data bus level.
  input  wire logic        PROG_DONE_FLAG     // Ready, low while busy.
);
  // ========================================================================
  // Sequencer states.
  typedef enum logic [3:0] {
    S_IDLE, S_SET, S_HIGH, S_LOW, S_NEXT, S_WRLOW, S_WAIT_BUSY,
    S_WAIT_READY, S_OELOW, S_SAMPLE, S_DONE
  } ppgm_state_e;

  // Load steps: command, address high, address low, data.
  typedef enum logic [1:0] {L_CMD, L_AHI, L_ALO, L_DAT} ppgm_load_e;

  // ========================================================================
  // Registers.
  ppgm_state_e        state, next_state;       // Sequencer state.
  ppgm_load_e         step, next_step;         // Current load step.
  ppgm_pkg::ppgm_pins_s pins, next_pins;       // Registered pin outputs.
  logic [19:0]        cnt, next_cnt;           // Step and pulse timer.
  logic [3:0]         op, next_op;             // Operation in progress.
  logic               half, next_half;         // Requested read half.
  logic               cmd_ld, next_cmd_ld;     // Reload command this time.
  logic               ahi_ld, next_ahi_ld;     // Reload high address.
  logic [15:0]        addr, next_addr;         // Address register.
  logic [7:0]         wdata, next_wdata;       // Write data register.
  logic [7:0]         rdata, next_rdata;       // Read back byte.
  logic               busy, next_busy;         // Operation running.
  logic               done, next_done;         // Sticky completion flag.
  logic               skipped, next_skipped;   // Last write was skipped.
  logic               range_err, next_range_err; // Address out of range.
  logic [31:0]        prdata, next_prdata;     // APB read data.
  logic               pready, next_pready;     // APB ready.
  logic               pslverr, next_pslverr;   // APB error.
  logic [1:0]         rdy_sync;                // Ready pin synchroniser.
  logic [7:0]         din_s1, din_s2;          // Data pin synchroniser.
  logic               start_req;               // Start written this cycle.
  logic [7:0]         cmd_byte;                // Command for the operation.
  logic               is_write;                // Operation drives the program pulse.

  // ========================================================================
  // Two flip-flop synchronisers for pins from the device.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rdy_sync <= 2'h3;
      din_s1   <= 8'h00;
      din_s2   <= 8'h00;
    end
    else
    begin
      rdy_sync <= {rdy_sync[0], PROG_DONE_FLAG};
      din_s1   <= DATA_IN;
      din_s2   <= din_s1;
    end
  end

  // Command byte that each operation loads.
  always_comb
  begin
    unique case (op)
      4'(ppgm_pkg::PPGM_OP_WR_EEPROM): cmd_byte = `PPGM_CMD_WR_EEPROM;
      4'(ppgm_pkg::PPGM_OP_RD_EEPROM): cmd_byte = `PPGM_CMD_RD_EEPROM;
      4'(ppgm_pkg::PPGM_OP_RD_FLASH):  cmd_byte = `PPGM_CMD_RD_FLASH;
      4'(ppgm_pkg::PPGM_OP_WR_FUSE):   cmd_byte = `PPGM_CMD_WR_FUSE;
      4'(ppgm_pkg::PPGM_OP_WR_LOCK):   cmd_byte = `PPGM_CMD_WR_LOCK;
      4'(ppgm_pkg::PPGM_OP_RD_FUSELK): cmd_byte = `PPGM_CMD_RD_FUSELK;
      4'(ppgm_pkg::PPGM_OP_RD_SIG):    cmd_byte = `PPGM_CMD_RD_SIG;
      default:                         cmd_byte = `PPGM_CMD_CHIP_ERASE;
    endcase
  end

  // Write-type operations drive the program pulse; the rest read.
  assign is_write = (op == 4'(ppgm_pkg::PPGM_OP_WR_EEPROM)) ||
                    (op == 4'(ppgm_pkg::PPGM_OP_WR_FUSE)) ||
                    (op == 4'(ppgm_pkg::PPGM_OP_WR_LOCK)) ||
                    (op == 4'(ppgm_pkg::PPGM_OP_CHIP_ERASE));

  assign start_req = PSEL && PENABLE && PWRITE && (PADDR == `PPGM_OFS_CTRL) &&
                     PWDATA[`PPGM_CTRL_START_BIT] && !busy;

  // ========================================================================
  // Next-value logic: APB slave and pin sequencer.
  always_comb
  begin
    next_state     = state;
    next_step      = step;
    next_pins      = pins;
    next_cnt       = cnt;
    next_op        = op;
    next_half      = half;
    next_cmd_ld    = cmd_ld;
    next_ahi_ld    = ahi_ld;
    next_addr      = addr;
    next_wdata     = wdata;
    next_rdata     = rdata;
    next_busy      = busy;
    next_done      = done;
    next_skipped   = skipped;
    next_range_err = range_err;
    next_prdata    = 32'h00000000;
    next_pslverr   = 1'b0;
    // No wait state: ready answers in the cycle after the setup phase.
    next_pready    = PSEL && !PENABLE;
    // Register writes, taken in the access phase.
    if (PSEL && PENABLE && PWRITE)
    begin
      unique case (PADDR)
        `PPGM_OFS_CTRL:
        begin
          if (start_req)
          begin
            next_op     = PWDATA[`PPGM_CTRL_OP_LSB +: 4];
            next_half   = PWDATA[`PPGM_CTRL_HALF_BIT];
            next_cmd_ld = PWDATA[`PPGM_CTRL_CMDLD_BIT];
            next_ahi_ld = PWDATA[`PPGM_CTRL_ADRHI_BIT];
            next_busy   = 1'b1;
            next_state  = S_IDLE;
          end
        end
        `PPGM_OFS_ADDR:   next_addr  = PWDATA[15:0];
        `PPGM_OFS_WDATA:  next_wdata = PWDATA[7:0];
        // Writing one to the done bit clears it.
        `PPGM_OFS_STATUS: next_done  = done && !PWDATA[0];
        default:          ;
      endcase
    end
    // Read data and error are decoded in the setup phase, so that they
    // stand in the access cycle together with ready.
    if (PSEL && !PENABLE)
    begin
      unique case (PADDR)
        `PPGM_OFS_CTRL:   next_prdata = {24'h000000, ahi_ld, cmd_ld, half, 1'b0, op};
        `PPGM_OFS_ADDR:   next_prdata = {16'h0000, addr};
        `PPGM_OFS_WDATA:  next_prdata = {24'h000000, wdata};
        `PPGM_OFS_STATUS: next_prdata = {27'h0, rdy_sync[1], range_err, skipped, busy, done};
        `PPGM_OFS_RDATA:  next_prdata = {24'h000000, rdata};
        default:          next_pslverr = 1'b1;
      endcase
      // Write transfers return zero read data.
      if (PWRITE)
        next_prdata = 32'h00000000;
    end
    // Pin sequencer.
    unique case (state)
      S_IDLE:
      begin
        if (busy)
        begin
          next_range_err = 1'b0;
          next_skipped   = 1'b0;
          if ((op == 4'(ppgm_pkg::PPGM_OP_WR_EEPROM) ||
               op == 4'(ppgm_pkg::PPGM_OP_RD_EEPROM)) &&
              addr[15:8] > `PPGM_EE_ADRHI_MAX)
          begin
            next_range_err = 1'b1;
            next_state     = S_DONE;
          end
          else if (op == 4'(ppgm_pkg::PPGM_OP_WR_EEPROM) &&
                   wdata == `PPGM_BLANK_BYTE)
          begin
            next_skipped = 1'b1;
            next_state   = S_DONE;
          end
          else
          begin
            next_step  = cmd_ld ? L_CMD : (ahi_ld ? L_AHI : L_ALO);
            next_state = S_SET;
          end
        end
      end
      S_SET:
      begin
        unique case (step)
          L_CMD: begin next_pins.action_code = `PPGM_ACT_CMD;
                   next_pins.byte_half_select = 1'b0; next_pins.data_out = cmd_byte; end
          L_AHI: begin next_pins.action_code = `PPGM_ACT_ADDR;
                   next_pins.byte_half_select = 1'b1; next_pins.data_out = addr[15:8]; end
          L_ALO: begin next_pins.action_code = `PPGM_ACT_ADDR;
                   next_pins.byte_half_select = 1'b0; next_pins.data_out = addr[7:0]; end
          L_DAT: begin next_pins.action_code = `PPGM_ACT_DATA;
                   next_pins.byte_half_select = 1'b0;
                   next_pins.data_out =
                     (op == 4'(ppgm_pkg::PPGM_OP_WR_FUSE)) ? (wdata | ~`PPGM_FUSE_KEEP_MASK) :
                     (op == 4'(ppgm_pkg::PPGM_OP_WR_LOCK)) ? (wdata | ~`PPGM_LOCK_KEEP_MASK) :
                     wdata; end
        endcase
        next_pins.data_oe_n = 1'b0;
        next_cnt   = 20'(`PPGM_STEP_CYC);
        next_state = S_HIGH;
      end
      S_HIGH:
      begin
        next_cnt = cnt - 20'h1;
        if (cnt == 20'h0)
        begin
          next_pins.load_strobe = 1'b1;
          next_cnt   = 20'(`PPGM_STEP_CYC);
          next_state = S_LOW;
        end
      end
      S_LOW:
      begin
        next_cnt = cnt - 20'h1;
        if (cnt == 20'h0)
        begin
          next_pins.load_strobe = 1'b0;
          next_cnt   = 20'(`PPGM_STEP_CYC);
          next_state = S_NEXT;
        end
      end
      S_NEXT:
      begin
        next_cnt = cnt - 20'h1;
        if (cnt == 20'h0)
        begin
          next_pins.action_code = `PPGM_ACT_IDLE;
          next_pins.data_oe_n   = 1'b1;
          next_cnt              = 20'(`PPGM_STEP_CYC);
          if (step == L_CMD && ahi_ld && op != 4'(ppgm_pkg::PPGM_OP_RD_SIG))
          begin next_step = L_AHI; next_state = S_SET; end
          else if ((step == L_CMD || step == L_AHI) &&
                   (op == 4'(ppgm_pkg::PPGM_OP_WR_EEPROM) ||
                    op == 4'(ppgm_pkg::PPGM_OP_RD_EEPROM) ||
                    op == 4'(ppgm_pkg::PPGM_OP_RD_FLASH) ||
                    op == 4'(ppgm_pkg::PPGM_OP_RD_SIG)))
          begin next_step = L_ALO; next_state = S_SET; end
          else if (step != L_DAT && (op == 4'(ppgm_pkg::PPGM_OP_WR_EEPROM) ||
                   op == 4'(ppgm_pkg::PPGM_OP_WR_FUSE) ||
                   op == 4'(ppgm_pkg::PPGM_OP_WR_LOCK)))
          begin next_step = L_DAT; next_state = S_SET; end
          else if (is_write)
          begin
            next_pins.byte_half_select = 1'b0;
            next_pins.write_pulse_n    = 1'b0;
            next_cnt = (op == 4'(ppgm_pkg::PPGM_OP_WR_FUSE)) ? 20'(`PPGM_FUSE_PULSE_CYC) :
                       (op == 4'(ppgm_pkg::PPGM_OP_CHIP_ERASE)) ?
                       20'(`PPGM_ERASE_PULSE_CYC) : 20'(`PPGM_STEP_CYC);
            next_state = S_WRLOW;
          end
          else
          begin
            next_pins.byte_half_select = half &&
              (op == 4'(ppgm_pkg::PPGM_OP_RD_FLASH) || op == 4'(ppgm_pkg::PPGM_OP_RD_FUSELK));
            next_state = S_OELOW;
          end
        end
      end
      S_WRLOW:
      begin
        next_cnt = cnt - 20'h1;
        if (cnt == 20'h0)
        begin
          next_pins.write_pulse_n = 1'b1;
          next_cnt   = 20'(`PPGM_STEP_CYC);
          next_state = (op == 4'(ppgm_pkg::PPGM_OP_WR_EEPROM) ||
                        op == 4'(ppgm_pkg::PPGM_OP_WR_LOCK)) ? S_WAIT_BUSY : S_DONE;
        end
      end
      S_WAIT_BUSY:
      begin
        next_cnt = cnt - 20'h1;
        if (cnt == 20'h0)
          next_state = S_WAIT_READY;
      end
      S_WAIT_READY:
      begin
        if (rdy_sync[1])
          next_state = S_DONE;
      end
      S_OELOW:
      begin
        next_pins.output_enable_n = 1'b0;
        next_cnt   = 20'(`PPGM_STEP_CYC);
        next_state = S_SAMPLE;
      end
      S_SAMPLE:
      begin
        next_cnt = cnt - 20'h1;
        if (cnt == 20'h0)
        begin
          next_rdata = din_s2;
          next_pins.output_enable_n = 1'b1;
          next_state = S_DONE;
        end
      end
      S_DONE:
      begin
        next_busy  = 1'b0;
        next_done  = 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // ========================================================================
  // State registers.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state <= S_IDLE;  step <= L_CMD;  cnt <= 20'h00000;  op <= 4'h0;
      pins  <= '{action_code: 2'h3, byte_half_select: 1'b0, load_strobe: 1'b0,
                 write_pulse_n: 1'b1, output_enable_n: 1'b1, data_out: 8'h00,
                 data_oe_n: 1'b1};
      half <= 1'b0;  cmd_ld <= 1'b0;  ahi_ld <= 1'b0;  addr <= 16'h0000;
      wdata <= 8'h00;  rdata <= 8'h00;  busy <= 1'b0;  done <= 1'b0;
      skipped <= 1'b0;  range_err <= 1'b0;  prdata <= 32'h00000000;
      pready <= 1'b0;  pslverr <= 1'b0;
    end
    else
    begin
      state <= next_state;  step <= next_step;  cnt <= next_cnt;  op <= next_op;
      pins <= next_pins;  half <= next_half;  cmd_ld <= next_cmd_ld;
      ahi_ld <= next_ahi_ld;  addr <= next_addr;  wdata <= next_wdata;
      rdata <= next_rdata;  busy <= next_busy;  done <= next_done;
      skipped <= next_skipped;  range_err <= next_range_err;
      prdata <= next_prdata;  pready <= next_pready;  pslverr <= next_pslverr;
    end
  end

  // Outputs straight from flip-flops.
  assign PRDATA           = prdata;
  assign PREADY           = pready;
  assign PSLVERR          = pslverr;
  assign ACTION_CODE      = pins.action_code;
  assign BYTE_HALF_SELECT = pins.byte_half_select;
  assign LOAD_STROBE      = pins.load_strobe;
  assign WRITE_PULSE_N    = pins.write_pulse_n;
  assign OUTPUT_ENABLE_N  = pins.output_enable_n;
  assign DATA_OUT         = pins.data_out;
  assign DATA_OE_N        = pins.data_oe_n;
endmodule
`default_nettype wire

// ===== sim/ppgm_host_monitor.sv
/* Checker of the programming host pins and APB handshake.
   Assumes a bind into ppgm_host; it sees only that module's ports. */
`timescale 1ns/100ps
`default_nettype none
module ppgm_host_monitor
(
  input wire logic       CORE_CLK,         // Clock.
  input wire logic       SYS_RST,          // Reset, high.
  input wire logic       PSEL,             // APB select.
  input wire logic       PENABLE,          // APB access phase.
  input wire logic       PREADY,           // APB ready.
  input wire logic       PSLVERR,          // APB error.
  input wire logic [1:0] ACTION_CODE,      // Load target code.
  input wire logic       BYTE_HALF_SELECT, // Half select.
  input wire logic       LOAD_STROBE,      // Load strobe.
  input wire logic       WRITE_PULSE_N,    // Program pulse.
  input wire logic       OUTPUT_ENABLE_N,  // Device output enable.
  input wire logic [7:0] DATA_OUT,         // Host bus value.
  input wire logic       DATA_OE_N,        // Host bus enable.
  input wire logic       PROG_DONE_FLAG    // Device ready.
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // ==========================================================
  // Strobe shape: six high cycles, then low.
  sequence s_strobe;
    LOAD_STROBE [*6] ##1 !LOAD_STROBE;
  endsequence
  property p_ready_once; PREADY |=> !PREADY; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_setup_ans; PSEL && !PENABLE |=> PREADY; endproperty
  a_setup_ans: assert property (p_setup_ans) else $error("no ready after setup");
  property p_err_ready; PSLVERR |-> PREADY; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_strobe; $rose(LOAD_STROBE) |-> s_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe width wrong");
  property p_load_hold;
    LOAD_STROBE |-> $stable(ACTION_CODE) && $stable(DATA_OUT) && $stable(BYTE_HALF_SELECT);
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("load inputs moved");
  property p_load_drive;
    LOAD_STROBE |-> !DATA_OE_N && OUTPUT_ENABLE_N && ACTION_CODE != 2'h3;
  endproperty
  a_load_drive: assert property (p_load_drive) else $error("load bus not driven");
  property p_no_fight; !OUTPUT_ENABLE_N |-> DATA_OE_N; endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus driven by both");
  property p_wr_ready; $fell(WRITE_PULSE_N) |-> PROG_DONE_FLAG; endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write while busy");
  property p_wr_alone;
    $fell(WRITE_PULSE_N) |-> (!LOAD_STROBE && OUTPUT_ENABLE_N) [*4];
  endproperty
  a_wr_alone: assert property (p_wr_alone) else $error("write pulse disturbed");
endmodule
`default_nettype wire

// ===== sim/ppgm_dev_model.sv
/* Behavioural model of the programmed device on the parallel port.
   Assumes the bench picks the byte write time through busy_cyc. */
`timescale 1ns/100ps
`default_nettype none
module ppgm_dev_model
#(
  parameter logic [23:0] SIG = 24'h96a53c  // Arbitrary identification bytes.
)
(
  input  wire logic       clk,       // Bench clock for timing.
  input  wire logic [1:0] code,      // Load target code.
  input  wire logic       half,      // Half select.
  input  wire logic       strobe,    // Load strobe.
  input  wire logic       wr_n,      // Program pulse.
  input  wire logic       oe_n,      // Output enable.
  input  wire logic [7:0] host_dout, // Host bus value.
  input  wire logic       host_oe_n, // Host bus enable.
  input  wire logic [31:0] busy_cyc, // Byte write time in cycles.
  output logic      [7:0] bus,       // Resolved bus level.
  output logic            ready      // Ready, low while busy.
);
  logic [7:0] cmd, alo, ahi, dat, fuse, lock, last, rd;  // Latched state.
  logic [7:0] ee [0:4095];                               // Erased array.
  int busy, wlow;                                        // Timers.
  initial begin
    cmd = 8'h00; alo = 8'h00; ahi = 8'h00; dat = 8'h00; last = 8'h00;
    fuse = 8'hff; lock = 8'hff; busy = 0; wlow = 0;
    foreach (ee[i]) ee[i] = 8'hff;
  end
  // latch on rising strobe, kept until reloaded.
  always @(posedge strobe)
    case (code)
      2'h0: if (half) ahi = bus; else alo = bus;
      2'h1: dat = bus;
      2'h2: cmd = bus;
      default: ;
    endcase
  // write starts at falling pulse; lock bits only clear.
  always @(negedge wr_n) begin
    if (cmd == 8'h11) ee[{ahi[3:0], alo}] = dat;
    if (cmd == 8'h20) lock = lock & dat;
    if (cmd == 8'h11 || cmd == 8'h20) busy = busy_cyc;
  end
  // fuses take effect only after a long enough pulse.
  always @(posedge wr_n)
    if (cmd == 8'h40 && wlow >= 50000) fuse = dat;
  // Pulse length and busy timers.
  always @(posedge clk) begin
    wlow = wr_n ? 0 : wlow + 1;
    if (busy > 0) busy = busy - 1;
    last <= bus;
  end
  // busy shows only once the pulse has ended.
  assign ready = !(busy > 0 && wr_n);
  always @* case (cmd)
    8'h02: rd = half ? ahi ^ 8'h3c : alo ^ 8'ha5;
    8'h03: rd = ee[{ahi[3:0], alo}];
    8'h04: rd = half ? lock | 8'hf9 : fuse | 8'hd4;
    8'h08: rd = SIG[8 * alo[1:0] +: 8];
    default: rd = 8'h00;
  endcase
  // device drives only with enable low; a free bus keeps toggling.
  assign bus = !host_oe_n ? host_dout : (!oe_n ? rd : ~last);
endmodule
`default_nettype wire

// ===== sim/test_ppgm_host.sv
/* Self-checking bench of ppgm_host against the device model.
   Assumes ppgm_cfg.svh offsets; chip erase is only started, then reset. */
`include "ppgm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module test_ppgm_host;
  logic CORE_CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic BYTE_HALF_SELECT, LOAD_STROBE, WRITE_PULSE_N, OUTPUT_ENABLE_N, DATA_OE_N, PROG_DONE_FLAG;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, seed, rv, st;
  logic [1:0] ACTION_CODE;
  logic [7:0] DATA_OUT, DATA_IN, d;
  logic [15:0] a;
  int err_total, cmp_count, busy_cyc, wlow;
  localparam logic [23:0] SIG = 24'h96a53c;  // Arbitrary identification bytes.
  ppgm_host uut (.*);
  ppgm_dev_model #(.SIG(SIG)) dev (.clk(CORE_CLK), .code(ACTION_CODE),
    .half(BYTE_HALF_SELECT), .strobe(LOAD_STROBE), .wr_n(WRITE_PULSE_N),
    .oe_n(OUTPUT_ENABLE_N), .host_dout(DATA_OUT), .host_oe_n(DATA_OE_N),
    .busy_cyc(busy_cyc), .bus(DATA_IN), .ready(PROG_DONE_FLAG));
  always #10 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) if (!WRITE_PULSE_N) wlow++;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One APB transfer; request held until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin @(posedge CORE_CLK); n++; end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      end_sim();
    end
    rv = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Start one operation, wait for done or range error, clear, fetch the byte.
  task automatic op(input ppgm_pkg::ppgm_op_e o, input logic [7:0] ctl,
                    input logic [15:0] ad, input logic [7:0] wd);
    int n;
    n = 0;
    apb(1'b1, `PPGM_OFS_ADDR, {16'h0000, ad});
    apb(1'b1, `PPGM_OFS_WDATA, {24'h000000, wd});
    apb(1'b1, `PPGM_OFS_CTRL, {24'h000000, ctl | 8'h10} | 32'(o));
    do begin apb(1'b0, `PPGM_OFS_STATUS, 32'h0); st = rv; n++; end
    while ((st[3:0] & 4'h9) == 4'h0 && n < 40000);
    if (n >= 40000)
    begin
      err_total++;
      end_sim();
    end
    apb(1'b1, `PPGM_OFS_STATUS, 32'h1);
    apb(1'b0, `PPGM_OFS_RDATA, 32'h0);
  endtask
  initial begin
    CORE_CLK = 1'b0; SYS_RST = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
    PADDR = 12'h000; PWDATA = 32'h0; err_total = 0; cmp_count = 0; seed = 35;
    busy_cyc = 300; wlow = 0;
    repeat (20) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    apb(1'b0, `PPGM_OFS_STATUS, 32'h0);
    chk("status_reset", rv[4:0], 5'h10);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", er, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      busy_cyc = i[0] ? 300 : 3;
      a = {4'h0, 12'(rnd())};
      d = 8'(rnd()) & 8'h7e;
      op(ppgm_pkg::PPGM_OP_WR_EEPROM, 8'hc0, a, d);
      chk("ee_wr_flags", st[3:2], 2'h0);
      op(ppgm_pkg::PPGM_OP_WR_EEPROM, 8'h00, a, 8'hff);
      chk("ee_skip", st[2], 1'b1);
      op(ppgm_pkg::PPGM_OP_RD_EEPROM, 8'hc0, a, 8'h00);
      chk("ee_byte", rv[7:0], d);
      a = 16'(rnd());
      op(ppgm_pkg::PPGM_OP_RD_FLASH, 8'hc0, a, 8'h00);
      chk("flash_lo", rv[7:0], a[7:0] ^ 8'ha5);
      op(ppgm_pkg::PPGM_OP_RD_FLASH, 8'h20, a, 8'h00);
      chk("flash_hi", rv[7:0], a[15:8] ^ 8'h3c);
    end
    op(ppgm_pkg::PPGM_OP_RD_EEPROM, 8'hc0, 16'h1000, 8'h00);
    chk("ee_range", st[3], 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      op(ppgm_pkg::PPGM_OP_RD_SIG, 8'h40, 16'(k), 8'h00);
      chk("sig", rv[7:0], SIG[8 * k +: 8]);
    end
    op(ppgm_pkg::PPGM_OP_WR_LOCK, 8'h40, 16'h0, 8'h0b);
    chk("lock_load", dev.dat, 8'hfb);
    op(ppgm_pkg::PPGM_OP_WR_LOCK, 8'h40, 16'h0, 8'hff);
    op(ppgm_pkg::PPGM_OP_RD_FUSELK, 8'h60, 16'h0, 8'h00);
    chk("lock_bits", rv[7:0], 8'hfb);
    d = 8'(rnd());
    wlow = 0;
    op(ppgm_pkg::PPGM_OP_WR_FUSE, 8'h40, 16'h0, d);
    chk("fuse_load", dev.dat, d | 8'hd4);
    chk("fuse_width", wlow >= 50000 && wlow <= 90000, 1'b1);
    op(ppgm_pkg::PPGM_OP_RD_FUSELK, 8'h40, 16'h0, 8'h00);
    chk("fuse_bits", rv[7:0], d | 8'hd4);
    apb(1'b1, `PPGM_OFS_CTRL, 32'h57);
    repeat (200) @(posedge CORE_CLK);
    apb(1'b0, `PPGM_OFS_STATUS, 32'h0);
    chk("erase_busy", {rv[1], WRITE_PULSE_N}, 2'h2);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    chk("reset_wr", WRITE_PULSE_N, 1'b1);
    SYS_RST <= 1'b0;
    apb(1'b0, `PPGM_OFS_STATUS, 32'h0);
    chk("reset_busy", rv[1], 1'b0);
    end_sim();
  end
endmodule
bind ppgm_host ppgm_host_monitor mon (.*);
`default_nettype wire
